// file: hdl/crm_regs.svh
// Register offsets, field positions and reset values of the receive mask and buffer status block.
// Operation
// - Selector 11 no mask, 10 mask set 2, 01 set 1, 00 set 0.
// - Selection word holds filter 15 in bits 15-14 down to filter 8 in 1-0.
// - Three mask sets, each a standard word and an extended word.
// - Standard mask bits 15-5 include identifier bits; clear bits are don't care.
// - Extended bits 17-16 in standard word bits 1-0, bits 15-0 in extended word.
// - Type check 1 accepts only frames whose type equals the filter select bit.
// - Type check 0 accepts either type when identifier bits match.
// - Standard mask word bits 4 and 2 always read zero.
// - Thirty-two full flags in two words, set when a message is stored.
// - Software clears flags only by writing zero; only the block sets them.
// - Thirty-two overflow flags, set when a frame is accepted for a buffer already full.
// - Every included identifier bit must equal the filter bit for a match.
// - Filter select 1 means extended frames only, 0 standard, under type check.
`ifndef CRM_REGS_SVH
`define CRM_REGS_SVH
// Register word indices on the register port.
`define CRM_ADDR_W        4
`define CRM_OFF_MASK_SEL  4'h0
`define CRM_OFF_M0_STD    4'h1
`define CRM_OFF_M0_EXT    4'h2
`define CRM_OFF_M1_STD    4'h3
`define CRM_OFF_M1_EXT    4'h4
`define CRM_OFF_M2_STD    4'h5
`define CRM_OFF_M2_EXT    4'h6
`define CRM_OFF_FULL_LO   4'h7
`define CRM_OFF_FULL_HI   4'h8
`define CRM_OFF_OVF_LO    4'h9
`define CRM_OFF_OVF_HI    4'ha
`define CRM_OFF_IRQ_STAT  4'hb
`define CRM_OFF_IRQ_MASK  4'hc
// Selector codes.
`define CRM_SEL_NONE      2'h3
// Standard mask word fields.
`define CRM_STD_SID_HI    15
`define CRM_STD_SID_LO    5
`define CRM_STD_TYPE_BIT  3
// Interrupt status bits.
`define CRM_IRQ_STORED    0
`define CRM_IRQ_OVERFLOW  1
// Reset values.
`define CRM_RST_WORD      16'h0000
`endif

// file: hdl/crm_pkg.sv
// Types shared by the receive mask and buffer status block.
package crm_pkg;

  // One acceptance mask set.
  typedef struct packed {
    logic [10:0] sid;
    logic        type_check;
    logic [17:0] eid;
  } crm_mask_t;

  // One acceptance filter as seen by the mask logic.
  typedef struct packed {
    logic [10:0] sid;
    logic        extended_select;
    logic [17:0] eid;
  } crm_filt_t;

  // Identifier of a received frame.
  typedef struct packed {
    logic [10:0] sid;
    logic        ide;
    logic [17:0] eid;
  } crm_frame_t;

endpackage

// file: hdl/crm_top.sv
// Receive mask selection, mask sets and receive buffer full and overflow flags.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "crm_regs.svh"

module crm_top
(
  // Clock and reset.
  input  wire logic                       clk,
  input  wire logic                       reset_n,
  // Register port.
  input  wire logic [`CRM_ADDR_W-1:0]     reg_addr,
  input  wire logic [15:0]                reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [15:0]                reg_rdata,
  // Filters 8 to 15, entry 0 is filter 8.
  input  wire crm_pkg::crm_filt_t [7:0]   filters,
  // Received frame from the protocol engine.
  input  wire logic                       frame_valid,
  input  wire crm_pkg::crm_frame_t        frame,
  input  wire logic [4:0]                 frame_buf,
  // Store request towards the message memory.
  output logic                            store_valid,
  output logic [4:0]                      store_buf,
  output logic [7:0]                      filter_hits,
  // Interrupt.
  output logic                            irq
);
  import crm_pkg::*;

  // ************************************************************
  // Register state
  // ************************************************************

  logic [15:0]  mask_sel_q;
  crm_mask_t    masks_q [3];
  logic [31:0]  full_q;
  logic [31:0]  full_d;
  logic [31:0]  ovf_q;
  logic [31:0]  ovf_d;
  logic [1:0]   irq_stat_q;
  logic [1:0]   irq_stat_d;
  logic [1:0]   irq_mask_q;
  logic [15:0]  reg_rdata_q;
  logic [15:0]  rdata_d;
  logic         store_q;
  logic [4:0]   store_buf_q;
  logic [7:0]   hits_q;

  // ************************************************************
  // Address decode
  // ************************************************************

  // One write enable per register word.
  wire wr_sel    = reg_wr && (reg_addr == `CRM_OFF_MASK_SEL);
  wire wr_m0_std = reg_wr && (reg_addr == `CRM_OFF_M0_STD);
  wire wr_m0_ext = reg_wr && (reg_addr == `CRM_OFF_M0_EXT);
  wire wr_m1_std = reg_wr && (reg_addr == `CRM_OFF_M1_STD);
  wire wr_m1_ext = reg_wr && (reg_addr == `CRM_OFF_M1_EXT);
  wire wr_m2_std = reg_wr && (reg_addr == `CRM_OFF_M2_STD);
  wire wr_m2_ext = reg_wr && (reg_addr == `CRM_OFF_M2_EXT);
  wire wr_ful_lo = reg_wr && (reg_addr == `CRM_OFF_FULL_LO);
  wire wr_ful_hi = reg_wr && (reg_addr == `CRM_OFF_FULL_HI);
  wire wr_ovf_lo = reg_wr && (reg_addr == `CRM_OFF_OVF_LO);
  wire wr_ovf_hi = reg_wr && (reg_addr == `CRM_OFF_OVF_HI);
  wire wr_istat  = reg_wr && (reg_addr == `CRM_OFF_IRQ_STAT);
  wire wr_imask  = reg_wr && (reg_addr == `CRM_OFF_IRQ_MASK);

  // Standard and extended write enables gathered per mask set.
  wire [2:0] wr_std = {wr_m2_std, wr_m1_std, wr_m0_std};
  wire [2:0] wr_ext = {wr_m2_ext, wr_m1_ext, wr_m0_ext};

  // ************************************************************
  // Filter matching
  // ************************************************************

  logic [7:0] hit;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_filt
      // Selector pair of this filter, filter 8 in the lowest pair.
      wire [1:0] sel = mask_sel_q[2*gi+1 -: 2];
      // No mask compares every bit and checks the frame type.
      wire       no_mask = (sel == `CRM_SEL_NONE);
      wire crm_mask_t m = no_mask ? '1 : masks_q[sel];
      wire crm_filt_t f = filters[gi];
      // Included bits must equal the filter bits.
      wire sid_ok = ((f.sid ^ frame.sid) & m.sid) == 11'h000;
      wire eid_ok = ((f.eid ^ frame.eid) & m.eid) == 18'h00000;
      // An extended frame needs the extended bits to match too.
      wire id_ok = sid_ok && (!frame.ide || eid_ok);
      // Under type check the frame type must follow the filter.
      wire type_ok = !m.type_check || (frame.ide == f.extended_select);
      assign hit[gi] = id_ok && type_ok;
    end
  endgenerate

  // A frame is accepted when any filter matches.
  wire accept = frame_valid && (|hit);
  // Accepted frame aimed at a buffer that is still full.
  wire target_full = full_q[frame_buf];
  wire do_store    = accept && !target_full;
  wire do_ovf      = accept && target_full;

  // ************************************************************
  // Flag next values
  // ************************************************************

  // Software write keeps ones and clears zeros; a set from the
  // block in the same cycle wins over the clear.
  wire [31:0] full_keep = {wr_ful_hi ? reg_wdata : 16'hffff,
                           wr_ful_lo ? reg_wdata : 16'hffff};
  wire [31:0] ovf_keep  = {wr_ovf_hi ? reg_wdata : 16'hffff,
                           wr_ovf_lo ? reg_wdata : 16'hffff};
  wire [31:0] buf_onehot = 32'h00000001 << frame_buf;

  // Flags set only by the block, cleared only by zero writes.
  always_comb
  begin
    full_d = (full_q & full_keep) | (do_store ? buf_onehot : 32'h00000000);
    ovf_d  = (ovf_q & ovf_keep) | (do_ovf ? buf_onehot : 32'h00000000);
  end

  // Interrupt status: write one to clear, new events win.
  always_comb
  begin
    irq_stat_d = irq_stat_q & ~(wr_istat ? reg_wdata[1:0] : 2'h0);
    irq_stat_d[`CRM_IRQ_STORED]   = irq_stat_d[`CRM_IRQ_STORED] | do_store;
    irq_stat_d[`CRM_IRQ_OVERFLOW] = irq_stat_d[`CRM_IRQ_OVERFLOW] | do_ovf;
  end

  // ************************************************************
  // Read data selection
  // ************************************************************

  // Standard mask word image, bits 4 and 2 read as zero.
  function automatic logic [15:0] std_word(input crm_mask_t m);
    std_word = {m.sid, 1'b0, m.type_check, 1'b0, m.eid[17:16]};
  endfunction

  // Unmapped words and idle cycles read as zero.
  always_comb
  begin
    rdata_d = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `CRM_OFF_MASK_SEL : rdata_d = mask_sel_q;
        `CRM_OFF_M0_STD   : rdata_d = std_word(masks_q[0]);
        `CRM_OFF_M0_EXT   : rdata_d = masks_q[0].eid[15:0];
        `CRM_OFF_M1_STD   : rdata_d = std_word(masks_q[1]);
        `CRM_OFF_M1_EXT   : rdata_d = masks_q[1].eid[15:0];
        `CRM_OFF_M2_STD   : rdata_d = std_word(masks_q[2]);
        `CRM_OFF_M2_EXT   : rdata_d = masks_q[2].eid[15:0];
        `CRM_OFF_FULL_LO  : rdata_d = full_q[15:0];
        `CRM_OFF_FULL_HI  : rdata_d = full_q[31:16];
        `CRM_OFF_OVF_LO   : rdata_d = ovf_q[15:0];
        `CRM_OFF_OVF_HI   : rdata_d = ovf_q[31:16];
        `CRM_OFF_IRQ_STAT : rdata_d = {14'h0000, irq_stat_q};
        `CRM_OFF_IRQ_MASK : rdata_d = {14'h0000, irq_mask_q};
        default           : rdata_d = 16'h0000;
      endcase
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************

  // Mask selection and interrupt mask.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mask_sel_q <= `CRM_RST_WORD;
      irq_mask_q <= 2'h0;
    end
    else
    begin
      if (wr_sel)
        mask_sel_q <= reg_wdata;
      if (wr_imask)
        irq_mask_q <= reg_wdata[1:0];
    end
  end

  // Three mask sets, each written as a standard and an extended word.
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_mask
      always_ff @(posedge clk)
      begin
        if (!reset_n)
          masks_q[gi] <= '0;
        else if (wr_std[gi])
          masks_q[gi] <= {reg_wdata[`CRM_STD_SID_HI:`CRM_STD_SID_LO],
                          reg_wdata[`CRM_STD_TYPE_BIT],
                          reg_wdata[1:0], masks_q[gi].eid[15:0]};
        else if (wr_ext[gi])
          masks_q[gi].eid[15:0] <= reg_wdata;
      end
    end
  endgenerate

  // ************************************************************
  // Status, store request and read data
  // ************************************************************

  // Flags, interrupt status and the store pulse.
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      full_q      <= 32'h00000000;
      ovf_q       <= 32'h00000000;
      irq_stat_q  <= 2'h0;
      store_q     <= 1'b0;
      store_buf_q <= 5'h00;
      hits_q      <= 8'h00;
      reg_rdata_q <= 16'h0000;
    end
    else
    begin
      full_q      <= full_d;
      ovf_q       <= ovf_d;
      irq_stat_q  <= irq_stat_d;
      store_q     <= do_store;
      store_buf_q <= accept ? frame_buf : store_buf_q;
      hits_q      <= frame_valid ? hit : hits_q;
      reg_rdata_q <= rdata_d;
    end
  end

  // Outputs.
  assign reg_rdata   = reg_rdata_q;
  assign store_valid = store_q;
  assign store_buf   = store_buf_q;
  assign filter_hits = hits_q;
  assign irq         = |(irq_stat_q & irq_mask_q);

endmodule
`default_nettype wire

// file: bench/crm_checker.sv
// Concurrent checks on the ports of the receive mask and buffer status block.
`timescale 1ns/100ps
`default_nettype none
`include "crm_regs.svh"
module crm_checker
(
  // Clock, reset and register port.
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic [`CRM_ADDR_W-1:0]  reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [15:0]             reg_rdata,
  // Filters, frame port, store side and interrupt.
  input wire crm_pkg::crm_filt_t [7:0] filters,
  input wire logic                    frame_valid,
  input wire crm_pkg::crm_frame_t     frame,
  input wire logic [4:0]              frame_buf,
  input wire logic                    store_valid,
  input wire logic [4:0]              store_buf,
  input wire logic [7:0]              filter_hits,
  input wire logic                    irq
);
  import crm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // A store in the same cycle as a read of the low full word.
  sequence stored_read_s;
    store_valid && reg_rd && reg_addr == `CRM_OFF_FULL_LO && !store_buf[4];
  endsequence
  // A further frame for the buffer that has just been filled.
  sequence refill_s;
    store_valid && frame_valid && frame_buf == store_buf;
  endsequence
  // Each check ties an output to the input that caused it.
  rdata_idle_a: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
    else $error("read data seen without a read");
  std_zero_a: assert property ($past(reg_rd) && ($past(reg_addr) inside {4'h1, 4'h3, 4'h5})
    |-> reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("unimplemented mask bits read as one");
  store_cause_a: assert property (store_valid |-> $past(frame_valid))
    else $error("store without a frame");
  store_buf_a: assert property (store_valid |-> store_buf == $past(frame_buf))
    else $error("store to the wrong buffer");
  store_hit_a: assert property (store_valid |-> filter_hits != 8'h00)
    else $error("store without a filter hit");
  full_read_a: assert property (stored_read_s |=> reg_rdata[$past(store_buf[3:0])] == 1'b1)
    else $error("full flag not set by a store");
  ovf_block_a: assert property (refill_s |=> !store_valid)
    else $error("store into a full buffer");
  irq_rise_a: assert property ($rose(irq) |-> $past(frame_valid) || $past(reg_wr))
    else $error("interrupt rose without cause");
endmodule
bind crm_top crm_checker crm_checker_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filters(filters),
  .frame_valid(frame_valid), .frame(frame), .frame_buf(frame_buf), .store_valid(store_valid),
  .store_buf(store_buf), .filter_hits(filter_hits), .irq(irq));
`default_nettype wire

// file: bench/crm_bus_src.sv
// Frame source standing in for the bus side of the receive path.
`timescale 1ns/100ps
`default_nettype none
module crm_bus_src
(
  // Clock, reset and bench commands.
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                send,
  input  wire crm_pkg::crm_frame_t fr_in,
  input  wire logic [4:0]          buf_in,
  // Frame port towards the block.
  output logic                     frame_valid,
  output crm_pkg::crm_frame_t      frame,
  output logic [4:0]               frame_buf
);
  import crm_pkg::*;
  // Between frames the lines toggle, so a stale identifier never looks steady.
  always_ff @(posedge clk)
  begin
    frame_valid <= reset_n && send;
    frame       <= !reset_n ? '0 : (send ? fr_in : ~frame);
    frame_buf   <= !reset_n ? '0 : (send ? buf_in : ~frame_buf);
  end
endmodule
`default_nettype wire

// file: bench/crm_top_tb_top.sv
// Self-checking bench for the receive mask and buffer status block.
`timescale 1ns/100ps
`default_nettype none
`include "crm_regs.svh"
module crm_top_tb_top;
  import crm_pkg::*;
  logic            clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, send = 1'b0;
  logic [3:0]      reg_addr = 4'h0;
  logic [15:0]     reg_wdata = 16'h0000, reg_rdata;
  logic            frame_valid, store_valid, irq;
  crm_filt_t [7:0] filters;
  crm_frame_t      fr_in = '0, frame;
  logic [4:0]      buf_in = 5'h00, frame_buf, store_buf;
  logic [7:0]      filter_hits;
  int              fails = 0, check_count = 0, cyc = 0;
  crm_top crm_top_i (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .filters(filters), .frame_valid(frame_valid), .frame(frame),
    .frame_buf(frame_buf), .store_valid(store_valid), .store_buf(store_buf), .filter_hits(filter_hits), .irq(irq));
  crm_bus_src crm_bus_src_i (.clk(clk), .reset_n(reset_n), .send(send), .fr_in(fr_in), .buf_in(buf_in),
    .frame_valid(frame_valid), .frame(frame), .frame_buf(frame_buf));
  // Clock and a cycle ceiling that cuts a hang short.
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // Register port cycles: one-cycle strobes, read data in the following cycle.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("read data", e, reg_rdata);
  endtask
  // Offers one frame for n consecutive cycles through the bus model.
  task automatic fr(input crm_frame_t s, input logic [4:0] b, input int n);
    @(posedge clk);
    send <= 1'b1;
    fr_in <= s;
    buf_in <= b;
    repeat (n) @(posedge clk);
    send <= 1'b0;
  endtask
  // Every word reads zero after reset, and an unmapped write leaves no trace.
  task automatic reset_scen();
    wr(4'hf, 16'hffff);
    for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
  endtask
  // Four selector codes against mismatched, matched and extended identifiers.
  task automatic filter_scen();
    crm_frame_t tf [6] = '{{11'h155, 1'b0, 18'h00000}, {11'h155, 1'b1, 18'h00000}, {11'h0aa, 1'b0, 18'h00000},
      {11'h0aa, 1'b1, 18'h00002}, {11'h0aa, 1'b1, 18'h10000}, {11'h0aa, 1'b1, 18'h00001}};
    logic [7:0] th [6] = '{8'h06, 8'h02, 8'h7f, 8'h82, 8'h02, 8'h02};
    wr(`CRM_OFF_M0_STD, 16'hffff);
    rd(`CRM_OFF_M0_STD, 16'hffeb);
    wr(`CRM_OFF_M0_EXT, 16'h0001);
    wr(`CRM_OFF_M2_STD, 16'h0008);
    wr(`CRM_OFF_MASK_SEL, 16'h00e4);
    rd(`CRM_OFF_MASK_SEL, 16'h00e4);
    for (int k = 0; k < 6; k++)
    begin
      fr(tf[k], 5'(16 + k), 1);
      @(posedge clk);
      #1 chk("filter hits", {8'h00, th[k]}, {8'h00, filter_hits});
      chk("store valid", 16'h0001, {15'h0000, store_valid});
    end
    rd(`CRM_OFF_FULL_HI, 16'h003f);
    // The other mask words take what is written, unimplemented bits dropped.
    wr(`CRM_OFF_M1_STD, 16'h1234);
    rd(`CRM_OFF_M1_STD, 16'h1220);
    wr(`CRM_OFF_M1_EXT, 16'ha5a5);
    rd(`CRM_OFF_M1_EXT, 16'ha5a5);
    wr(`CRM_OFF_M2_EXT, 16'h5a5a);
    rd(`CRM_OFF_M2_EXT, 16'h5a5a);
  endtask
  // Back-to-back frames into one buffer, then clearing by software.
  task automatic flag_scen();
    fork
      fr({11'h0aa, 1'b0, 18'h00000}, 5'h05, 2);
      begin
        repeat (2) @(posedge clk);
        rd(`CRM_OFF_FULL_LO, 16'h0020);
      end
    join
    chk("store valid", 16'h0000, {15'h0000, store_valid});
    chk("store buf", 16'h0005, {11'h000, store_buf});
    rd(`CRM_OFF_OVF_LO, 16'h0020);
    wr(`CRM_OFF_FULL_LO, 16'hffff);
    rd(`CRM_OFF_FULL_LO, 16'h0020);
    wr(`CRM_OFF_FULL_LO, 16'hffdf);
    rd(`CRM_OFF_FULL_LO, 16'h0000);
  endtask
  // Interrupt raised by the mask, kept by the other event, then masked.
  task automatic irq_scen();
    chk("irq", 16'h0000, {15'h0000, irq});
    wr(`CRM_OFF_IRQ_MASK, 16'h0003);
    chk("irq", 16'h0001, {15'h0000, irq});
    wr(`CRM_OFF_IRQ_STAT, 16'h0001);
    chk("irq", 16'h0001, {15'h0000, irq});
    rd(`CRM_OFF_IRQ_STAT, 16'h0002);
    wr(`CRM_OFF_IRQ_MASK, 16'h0001);
    chk("irq", 16'h0000, {15'h0000, irq});
  endtask
  // Main sequence: filters 8 to 14 take standard frames, filter 15 extended ones.
  initial
  begin
    filters = {8{11'h0aa, 1'b0, 18'h00000}};
    filters[7].extended_select = 1'b1;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    reset_scen();
    filter_scen();
    flag_scen();
    irq_scen();
    close_out();
  end
endmodule
`default_nettype wire
